// ===== common/rx_pkt_pkg.sv
package rx_pkt_pkg;

   // register indices, byte address is four times the index
   localparam logic [9:0] IDX_CTRL = 10'h101;
   localparam logic [9:0] IDX_MAX_LO = 10'h102;
   localparam logic [9:0] IDX_MAX_HI = 10'h103;
   localparam logic [9:0] IDX_LIVE = 10'h104;
   localparam logic [9:0] IDX_LATCH = 10'h105;
   localparam logic [9:0] IDX_IRQ_EN = 10'h106;
   localparam logic [9:0] IDX_CNT_LO = 10'h108;
   localparam logic [9:0] IDX_CNT_MID = 10'h109;
   localparam logic [9:0] IDX_CNT_HI = 10'h10A;
   localparam logic [9:0] IDX_MIN = 10'h118;
   localparam logic [9:0] IDX_CNT_CLR = 10'h119;

   // control bit positions
   localparam int CTRL_CC_BIT = 0;
   localparam int CTRL_FCS16_BIT = 4;
   localparam int CTRL_FCS_DIS_BIT = 5;
   localparam int CTRL_X86_BIT = 6;

   // latched and enable bit positions
   localparam int EV_FCS_PKT = 7;
   localparam int EV_ABORT_PKT = 6;
   localparam int EV_PARTIAL_PKT = 5;
   localparam int EV_SHORT_PKT = 4;
   localparam int EV_LONG_PKT = 3;
   localparam int EV_FCS_CNT = 2;
   localparam int EV_ABORT_CNT = 1;
   localparam int EV_SIZE_CNT = 0;

   // reset values and limits
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [15:0] MAX_RESET = 16'h07E0;
   localparam logic [15:0] MIN_RESET = 16'h0004;
   localparam logic [15:0] MAX_CEILING = 16'h07E0;
   localparam logic [15:0] FCS32_BYTES = 16'h0004;
   localparam logic [15:0] FCS16_BYTES = 16'h0002;
   localparam logic [15:0] NO_FCS_BYTES = 16'h0000;
   localparam logic [23:0] CNT_MAX = 24'hFFFFFF;

   // one received byte with end-of-packet status
   typedef struct packed {
      logic [7:0] data;
      logic last;
      logic abort;
      logic fcs_err;
      logic partial;
   } in_beat_t;

   // one forwarded byte; drop is valid with last
   typedef struct packed {
      logic [7:0] data;
      logic last;
      logic drop;
   } out_beat_t;

endpackage

// ===== design/rx_packet_size_status_events.sv
// Behaviour
// - max size counts bytes incl FCS, no stuffing
// - max below min discards every packet
// - clear channel cuts stream into max-size chunks
// - max size capped at 2016 plus FCS
// - X.86 header bytes count toward length
// - live bits show error counts non-zero
// - bit 7 latches FCS errored packet
// - bit 6 latches aborted packet
// - bit 5 latches non-whole-byte packet
// - bit 4 latches packet below minimum size
// - bit 3 latches packet above maximum size
// - bits 2..0 latch rise of live bits
// - per-bit enables gate latched bits to interrupt
// - 24-bit packet count over three byte registers
// - count packets stored without abort
// - clear channel disables all packet checks
//
// Design decision made here: the Wishbone interface to the registers.
`timescale 1ns/1ns
`default_nettype none

module rx_packet_size_status_events #(
   parameter int ADDR_W = 12
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [ADDR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // receive byte stream in
   input wire logic in_valid_i,
   input wire rx_pkt_pkg::in_beat_t in_i,
   // processed byte stream out
   output logic out_valid_o,
   output var rx_pkt_pkg::out_beat_t out_o,
   // interrupt
   output logic irq_o
);

   ////////////////////////////////////////////////////////////////////////
   // registers and nets

   logic [7:0] ctrl_reg;
   logic [15:0] max_reg;
   logic [15:0] min_reg;
   logic [7:0] latch_reg;
   logic [7:0] latch_next;
   logic [7:0] irq_en_reg;
   logic [23:0] total_reg;
   logic [23:0] fcs_cnt_reg;
   logic [23:0] abort_cnt_reg;
   logic [23:0] size_cnt_reg;
   logic [2:0] live_reg;
   logic [2:0] live_prev_reg;
   logic [15:0] len_reg;
   logic [15:0] len_next;
   logic [15:0] fcs_bytes;
   logic [15:0] max_eff;
   logic [7:0] events;
   logic [9:0] idx;
   logic bus_req;
   logic wr_take;
   logic wr_fire;
   logic rd_fire;
   logic in_fire;
   logic pkt_end;
   logic clear_ch;
   logic x86_mode;
   logic too_long;
   logic too_short;
   logic discard_all;
   logic drop;
   logic stored;
   logic chunk_end;
   logic [2:0] cnt_clr;
   logic [7:0] lat_clr;

   ////////////////////////////////////////////////////////////////////////
   // bus decode

   assign idx = wb_adr_i[11:2];
   assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   // writes land at the edge where the master sees ack
   assign wr_take = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
   assign wr_fire = wr_take && wb_sel_i[0];
   assign rd_fire = bus_req && !wb_we_i;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= bus_req;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_dat_o <= 32'h00000000;
      end else if (rd_fire) begin
         unique case (idx)
            rx_pkt_pkg::IDX_CTRL: wb_dat_o <= {24'h000000, ctrl_reg};
            rx_pkt_pkg::IDX_MAX_LO: wb_dat_o <= {24'h000000, max_reg[7:0]};
            rx_pkt_pkg::IDX_MAX_HI: wb_dat_o <= {24'h000000, max_reg[15:8]};
            rx_pkt_pkg::IDX_LIVE: wb_dat_o <= {29'h0, live_reg};
            rx_pkt_pkg::IDX_LATCH: wb_dat_o <= {24'h000000, latch_reg};
            rx_pkt_pkg::IDX_IRQ_EN: wb_dat_o <= {24'h000000, irq_en_reg};
            rx_pkt_pkg::IDX_CNT_LO: wb_dat_o <= {24'h000000, total_reg[7:0]};
            rx_pkt_pkg::IDX_CNT_MID: wb_dat_o <= {24'h000000, total_reg[15:8]};
            rx_pkt_pkg::IDX_CNT_HI: wb_dat_o <= {24'h000000, total_reg[23:16]};
            rx_pkt_pkg::IDX_MIN: wb_dat_o <= {16'h0000, min_reg};
            default: wb_dat_o <= 32'h00000000;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // configuration registers

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_reg <= rx_pkt_pkg::CTRL_RESET;
      end else if (wr_fire && idx == rx_pkt_pkg::IDX_CTRL) begin
         ctrl_reg <= wb_dat_i[7:0];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         max_reg <= rx_pkt_pkg::MAX_RESET;
      end else if (wr_fire && idx == rx_pkt_pkg::IDX_MAX_LO) begin
         max_reg[7:0] <= wb_dat_i[7:0];
      end else if (wr_fire && idx == rx_pkt_pkg::IDX_MAX_HI) begin
         max_reg[15:8] <= wb_dat_i[7:0];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         min_reg <= rx_pkt_pkg::MIN_RESET;
      end else if (wr_take && idx == rx_pkt_pkg::IDX_MIN) begin
         if (wb_sel_i[0]) begin
            min_reg[7:0] <= wb_dat_i[7:0];
         end
         if (wb_sel_i[1]) begin
            min_reg[15:8] <= wb_dat_i[15:8];
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_en_reg <= 8'h00;
      end else if (wr_fire && idx == rx_pkt_pkg::IDX_IRQ_EN) begin
         irq_en_reg <= wb_dat_i[7:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // size limits

   assign clear_ch = ctrl_reg[rx_pkt_pkg::CTRL_CC_BIT];
   assign x86_mode = ctrl_reg[rx_pkt_pkg::CTRL_X86_BIT];

   always_comb begin
      if (x86_mode) begin
         fcs_bytes = rx_pkt_pkg::FCS32_BYTES;
      end else if (ctrl_reg[rx_pkt_pkg::CTRL_FCS_DIS_BIT]) begin
         fcs_bytes = rx_pkt_pkg::NO_FCS_BYTES;
      end else if (ctrl_reg[rx_pkt_pkg::CTRL_FCS16_BIT]) begin
         fcs_bytes = rx_pkt_pkg::FCS16_BYTES;
      end else begin
         fcs_bytes = rx_pkt_pkg::FCS32_BYTES;
      end
   end

   // ceiling applies to any larger setting
   always_comb begin
      if (max_reg > rx_pkt_pkg::MAX_CEILING + fcs_bytes) begin
         max_eff = rx_pkt_pkg::MAX_CEILING + fcs_bytes;
      end else begin
         max_eff = max_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // packet length and verdict

   assign in_fire = in_valid_i;
   // destuffed bytes, header and FCS bytes all count
   assign len_next = (len_reg == 16'hFFFF) ? len_reg : len_reg + 16'h0001;
   assign pkt_end = in_fire && in_i.last && !clear_ch;
   assign too_long = len_next > max_eff;
   assign too_short = len_next < min_reg;
   assign discard_all = max_reg < min_reg;
   assign drop = too_long || too_short || discard_all;
   assign stored = pkt_end && !in_i.abort && !drop;
   assign chunk_end = clear_ch && in_fire && len_next >= max_eff;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         len_reg <= 16'h0000;
      end else if (pkt_end || chunk_end) begin
         len_reg <= 16'h0000;
      end else if (in_fire) begin
         len_reg <= len_next;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         out_valid_o <= 1'b0;
         out_o <= '0;
      end else begin
         out_valid_o <= in_fire;
         out_o.data <= in_i.data;
         out_o.last <= pkt_end || chunk_end;
         out_o.drop <= pkt_end && (drop || in_i.abort);
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         total_reg <= 24'h000000;
      end else if ((stored || chunk_end) &&
                   total_reg != rx_pkt_pkg::CNT_MAX) begin
         total_reg <= total_reg + 24'h000001;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // error counters behind the live bits

   assign cnt_clr = (wr_fire && idx == rx_pkt_pkg::IDX_CNT_CLR) ?
                    wb_dat_i[2:0] : 3'h0;

   always_ff @(posedge clk_i) begin
      if (rst_i || cnt_clr[2]) begin
         fcs_cnt_reg <= 24'h000000;
      end else if (pkt_end && in_i.fcs_err &&
                   fcs_cnt_reg != rx_pkt_pkg::CNT_MAX) begin
         fcs_cnt_reg <= fcs_cnt_reg + 24'h000001;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i || cnt_clr[1]) begin
         abort_cnt_reg <= 24'h000000;
      end else if (pkt_end && in_i.abort &&
                   abort_cnt_reg != rx_pkt_pkg::CNT_MAX) begin
         abort_cnt_reg <= abort_cnt_reg + 24'h000001;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i || cnt_clr[0]) begin
         size_cnt_reg <= 24'h000000;
      end else if (pkt_end && (too_long || too_short) &&
                   size_cnt_reg != rx_pkt_pkg::CNT_MAX) begin
         size_cnt_reg <= size_cnt_reg + 24'h000001;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         live_reg <= 3'h0;
         live_prev_reg <= 3'h0;
      end else begin
         live_reg <= {fcs_cnt_reg != 24'h000000, abort_cnt_reg != 24'h000000,
                      size_cnt_reg != 24'h000000};
         live_prev_reg <= live_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // latched events and interrupt

   always_comb begin
      events = 8'h00;
      events[rx_pkt_pkg::EV_FCS_PKT] = pkt_end && in_i.fcs_err;
      events[rx_pkt_pkg::EV_ABORT_PKT] = pkt_end && in_i.abort;
      events[rx_pkt_pkg::EV_PARTIAL_PKT] = pkt_end && in_i.partial;
      events[rx_pkt_pkg::EV_SHORT_PKT] = pkt_end && too_short;
      events[rx_pkt_pkg::EV_LONG_PKT] = pkt_end && too_long;
      events[2:0] = live_reg & ~live_prev_reg;
   end

   assign lat_clr = (wr_fire && idx == rx_pkt_pkg::IDX_LATCH) ?
                    wb_dat_i[7:0] : 8'h00;
   // a new event wins over a clear in the same cycle
   assign latch_next = (latch_reg & ~lat_clr) | events;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         latch_reg <= 8'h00;
      end else begin
         latch_reg <= latch_next;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= |(latch_reg & irq_en_reg);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");
   chk_fcs_latch: assert property (
      pkt_end && in_i.fcs_err |=> latch_reg[rx_pkt_pkg::EV_FCS_PKT])
      else $error("fcs errored packet not latched");
   chk_abort_latch: assert property (
      pkt_end && in_i.abort |=> latch_reg[rx_pkt_pkg::EV_ABORT_PKT])
      else $error("aborted packet not latched");
   chk_partial_latch: assert property (
      pkt_end && in_i.partial |=> latch_reg[rx_pkt_pkg::EV_PARTIAL_PKT])
      else $error("partial byte packet not latched");
   chk_short_latch: assert property (
      pkt_end && len_next < min_reg |=> latch_reg[rx_pkt_pkg::EV_SHORT_PKT])
      else $error("short packet not latched");
   chk_long_latch: assert property (
      pkt_end && len_next > max_eff |=> latch_reg[rx_pkt_pkg::EV_LONG_PKT])
      else $error("long packet not latched");
   chk_live_rise: assert property (
      $rose(fcs_cnt_reg != 24'h000000) |=> ##1
      latch_reg[rx_pkt_pkg::EV_FCS_CNT])
      else $error("live bit rise not latched");
   chk_sticky_hold: assert property (
      lat_clr == 8'h00 |=> (latch_reg & $past(latch_reg)) == $past(latch_reg))
      else $error("latched bit lost without clear");
   chk_irq_gate: assert property (
      (latch_reg & irq_en_reg) != 8'h00 [*2] |-> irq_o)
      else $error("enabled event gave no interrupt");
   chk_irq_masked: assert property (
      (latch_reg & irq_en_reg) == 8'h00 |=> !irq_o)
      else $error("interrupt without enabled event");
   chk_ceiling_cap: assert property (
      max_eff <= rx_pkt_pkg::MAX_CEILING + fcs_bytes && max_eff <= max_reg)
      else $error("effective maximum above ceiling");
   chk_discard_all: assert property (
      pkt_end && max_reg < min_reg |=> out_o.drop && out_o.last)
      else $error("packet kept while max below min");
   chk_chunk_cut: assert property (
      clear_ch && in_fire && len_next >= max_eff |=> out_o.last && out_valid_o)
      else $error("chunk not cut at maximum size");
   chk_count_step: assert property (
      stored && total_reg != rx_pkt_pkg::CNT_MAX |=>
      total_reg == $past(total_reg) + 24'h000001)
      else $error("packet count did not step");

   cov_long_pkt: cover property (pkt_end && too_long);
   cov_chunk_end: cover property (chunk_end ##1 in_fire [*2]);
   cov_irq_rise: cover property ($rose(irq_o));
   cov_clear_race: cover property (events != 8'h00 && lat_clr != 8'h00);

endmodule

`default_nettype wire

// ===== tb/rx_stream_source.sv
`timescale 1ns/1ns
`default_nettype none

module rx_stream_source (
   // clock
   input wire logic clk_i,
   // destuffed byte stream
   output logic in_valid_o,
   output var rx_pkt_pkg::in_beat_t beat_o
);
   integer seed = 32'hd1853e50;

   initial begin
      in_valid_o = 1'b0;
      beat_o = '0;
   end

   ////////////////////////////////////////////////////////////////////////
   // fl is {abort, fcs_err, partial}, given with the last byte only
   task automatic send(input int len, input logic [2:0] fl);
      for (int i = 0; i < len; i++) begin
         @(posedge clk_i);
         in_valid_o <= 1'b1;
         beat_o.data <= 8'($random(seed));
         beat_o.last <= (i == len - 1);
         beat_o.abort <= (i == len - 1) & fl[2];
         beat_o.fcs_err <= (i == len - 1) & fl[1];
         beat_o.partial <= (i == len - 1) & fl[0];
      end
      @(posedge clk_i);
      in_valid_o <= 1'b0;
      beat_o.data <= ~beat_o.data;
      beat_o.last <= 1'b0;
      beat_o.abort <= 1'b0;
      beat_o.fcs_err <= 1'b0;
      beat_o.partial <= 1'b0;
   endtask
endmodule

`default_nettype wire

// ===== tb/rx_packet_size_status_events_bench.sv
`timescale 1ns/1ns
`default_nettype none

module rx_packet_size_status_events_bench;
   logic clk_i, rst_i, wb_cyc, wb_stb, wb_we, wb_ack_o, in_valid;
   logic out_valid_o, irq_o, exp_drop;
   logic [11:0] wb_adr;
   logic [3:0] wb_sel;
   logic [31:0] wb_wdat, wb_dat_o, q;
   rx_pkt_pkg::in_beat_t in_beat;
   rx_pkt_pkg::out_beat_t out_o;
   int n_fail, cmp_count, exp_cnt, n_last, chunk;
   logic prev_valid = 1'b0;
   logic [7:0] prev_data;
   logic [7:0] exp_lat, exp_live, en;
   logic [7:0] ctl [2] = '{8'h20, 8'h40};
   int lim [2] = '{2016, 2020};

   rx_packet_size_status_events i_dut (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
      .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
      .wb_dat_i(wb_wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .in_valid_i(in_valid), .in_i(in_beat), .out_valid_o(out_valid_o),
      .out_o(out_o), .irq_o(irq_o)
   );

   rx_stream_source i_src (
      .clk_i(clk_i), .in_valid_o(in_valid), .beat_o(in_beat)
   );

   ////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value at %0t: seen %h expected %h",
                  $time, seen, exp);
      end
   endtask

   task automatic end_of_test();
      if (n_fail == 0 && cmp_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic bus(input logic we, input logic [9:0] idx,
                      input logic [31:0] d, input logic [3:0] sel);
      @(posedge clk_i);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= we;
      wb_adr <= {idx, 2'b00};
      wb_sel <= sel;
      wb_wdat <= d;
      do begin
         @(posedge clk_i);
      end while (wb_ack_o !== 1'b1);
      q = wb_dat_o;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
   endtask

   task automatic wr(input logic [9:0] idx, input logic [7:0] d);
      bus(1'b1, idx, {24'h0, d}, 4'h1);
   endtask

   task automatic rdc(input logic [9:0] idx, input logic [7:0] exp);
      bus(1'b0, idx, 32'h0, 4'h1);
      check(q, {24'h0, exp});
   endtask

   task automatic pkt(input int len, input logic [2:0] fl,
                      input logic [7:0] lat, input logic [7:0] live,
                      input logic drop, input int inc);
      exp_drop = drop;
      n_last = 0;
      i_src.send(len, fl);
      repeat (5) @(posedge clk_i);
      exp_lat = exp_lat | lat;
      exp_live = exp_live | live;
      exp_cnt = exp_cnt + inc;
      check(n_last, (chunk > 0) ? len / chunk : 1);
      rdc(rx_pkt_pkg::IDX_LATCH, exp_lat);
      rdc(rx_pkt_pkg::IDX_LIVE, exp_live);
      rdc(rx_pkt_pkg::IDX_CNT_LO, 8'(exp_cnt));
      check(32'(irq_o), 32'((exp_lat & en) != 8'h00));
   endtask

   ////////////////////////////////////////////////////////////////////////
   always @(posedge clk_i) begin
      if (!rst_i) begin
         check(32'(out_valid_o), 32'(prev_valid));
         if (prev_valid)
            check(32'(out_o.data), 32'(prev_data));
      end
      if (out_valid_o === 1'b1 && out_o.last === 1'b1) begin
         n_last++;
         check(32'(out_o.drop), 32'(exp_drop));
      end
      prev_valid <= in_valid;
      prev_data <= in_beat.data;
   end

   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   initial begin
      repeat (60000) @(posedge clk_i);
      n_fail++;
      end_of_test();
   end

   initial begin
      {wb_cyc, wb_stb, wb_we, wb_adr, wb_sel, wb_wdat} = '0;
      {n_fail, cmp_count, exp_cnt, exp_drop} = '0;
      {exp_lat, exp_live} = 16'h0000;
      en = 8'h80;
      rst_i = 1'b1;
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      rdc(rx_pkt_pkg::IDX_IRQ_EN, 8'h00);
      rdc(rx_pkt_pkg::IDX_CNT_HI, 8'h00);
      rdc(rx_pkt_pkg::IDX_MAX_LO, 8'hE0);
      rdc(rx_pkt_pkg::IDX_MAX_HI, 8'h07);
      rdc(10'h3FF, 8'h00);
      wr(rx_pkt_pkg::IDX_IRQ_EN, en);
      pkt(10, 3'b000, 8'h00, 8'h00, 1'b0, 1);
      pkt(8, 3'b010, 8'h84, 8'h04, 1'b0, 1);
      pkt(8, 3'b100, 8'h42, 8'h02, 1'b1, 0);
      pkt(8, 3'b001, 8'h20, 8'h00, 1'b0, 1);
      pkt(2, 3'b000, 8'h11, 8'h01, 1'b1, 0);
      wr(rx_pkt_pkg::IDX_LATCH, 8'hFF);
      exp_lat = 8'h00;
      rdc(rx_pkt_pkg::IDX_LATCH, 8'h00);
      check(32'(irq_o), 32'h0);
      wr(rx_pkt_pkg::IDX_LIVE, 8'hFF);
      rdc(rx_pkt_pkg::IDX_LIVE, exp_live);
      bus(1'b1, rx_pkt_pkg::IDX_IRQ_EN, 32'h0000_00FF, 4'h2);
      rdc(rx_pkt_pkg::IDX_IRQ_EN, en);
      wr(rx_pkt_pkg::IDX_MAX_LO, 8'h08);
      wr(rx_pkt_pkg::IDX_MAX_HI, 8'h00);
      pkt(9, 3'b000, 8'h08, 8'h00, 1'b1, 0);
      pkt(8, 3'b000, 8'h00, 8'h00, 1'b0, 1);
      en = 8'h08;
      wr(rx_pkt_pkg::IDX_IRQ_EN, en);
      rdc(rx_pkt_pkg::IDX_IRQ_EN, en);
      check(32'(irq_o), 32'h1);
      wr(rx_pkt_pkg::IDX_LATCH, 8'h08);
      exp_lat = 8'h00;
      wr(rx_pkt_pkg::IDX_MAX_LO, 8'hFF);
      wr(rx_pkt_pkg::IDX_MAX_HI, 8'hFF);
      for (int k = 0; k < 2; k++) begin
         wr(rx_pkt_pkg::IDX_CTRL, ctl[k]);
         pkt(lim[k] + 1, 3'b000, 8'h08, 8'h00, 1'b1, 0);
         pkt(lim[k], 3'b000, 8'h00, 8'h00, 1'b0, 1);
      end
      wr(rx_pkt_pkg::IDX_MAX_LO, 8'h03);
      wr(rx_pkt_pkg::IDX_MAX_HI, 8'h00);
      pkt(4, 3'b000, 8'h08, 8'h00, 1'b1, 0);
      wr(rx_pkt_pkg::IDX_CTRL, 8'h01);
      chunk = 3;
      pkt(7, 3'b110, 8'h00, 8'h00, 1'b0, 2);
      rdc(rx_pkt_pkg::IDX_CNT_LO, 8'(exp_cnt));
      rdc(rx_pkt_pkg::IDX_CNT_MID, 8'(exp_cnt >> 8));
      rdc(rx_pkt_pkg::IDX_CNT_HI, 8'(exp_cnt >> 16));
      end_of_test();
   end
endmodule

`default_nettype wire
